/* rtl/tmw_mode_decode.sv */
`default_nettype none
// decodes the 4-bit waveform mode into counting behaviour
module tmw_mode_decode (
    input  wire logic [3:0] waveform_mode_sel,
    output tmw_pkg::tmw_fam_t  family,
    output tmw_pkg::tmw_tsrc_t top_src,
    output logic            top_from_icr,
    output logic            toggle_a_ok
);
    // table lookup of family, top source and toggle permission
    always_comb begin
        family       = tmw_pkg::FAM_NORMAL;
        top_src      = tmw_pkg::TSRC_MAX;
        top_from_icr = 1'b0;
        toggle_a_ok  = 1'b1;
        case (waveform_mode_sel)
            4'h0: begin // free count to max
                family = tmw_pkg::FAM_NORMAL;
            end
            4'h1, 4'h2, 4'h3: begin // fixed-top phase correct
                family = tmw_pkg::FAM_PHASE;
                toggle_a_ok = 1'b0;
                top_src = (waveform_mode_sel == 4'h1) ? tmw_pkg::TSRC_8 :
                          (waveform_mode_sel == 4'h2) ? tmw_pkg::TSRC_9 :
                                                        tmw_pkg::TSRC_10;
            end
            4'h4, 4'hC: begin // clear on match
                family = tmw_pkg::FAM_NORMAL;
                top_src = tmw_pkg::TSRC_CMPA;
                top_from_icr = (waveform_mode_sel == tmw_pkg::MODE_CTC_ICR);
            end
            4'h5, 4'h6, 4'h7: begin // fixed-top fast pwm
                family = tmw_pkg::FAM_FAST;
                toggle_a_ok = 1'b0;
                top_src = (waveform_mode_sel == 4'h5) ? tmw_pkg::TSRC_8 :
                          (waveform_mode_sel == 4'h6) ? tmw_pkg::TSRC_9 :
                                                        tmw_pkg::TSRC_10;
            end
            4'h8, 4'h9: begin // phase and frequency correct
                family = tmw_pkg::FAM_PFC;
                top_src = tmw_pkg::TSRC_CMPA;
                top_from_icr = (waveform_mode_sel == tmw_pkg::MODE_PFC_ICR);
            end
            4'hA, 4'hB: begin // variable-top phase correct
                family = tmw_pkg::FAM_PHASE;
                top_src = tmw_pkg::TSRC_CMPA;
                top_from_icr = (waveform_mode_sel != tmw_pkg::MODE_PC_OCR);
            end
            4'hE, 4'hF: begin // variable-top fast pwm
                family = tmw_pkg::FAM_FAST;
                top_src = tmw_pkg::TSRC_CMPA;
                top_from_icr = (waveform_mode_sel == tmw_pkg::MODE_FP_ICR);
            end
            default: begin // reserved 13 behaves as normal
                family = tmw_pkg::FAM_NORMAL;
            end
        endcase
    end
endmodule : tmw_mode_decode
`default_nettype wire

/* rtl/tmw_pkg.sv */
`default_nettype none
package tmw_pkg;
    // register byte addresses on the bus
    localparam logic [7:0] ADDR_OUT_MODE   = 8'h00; // output mode control
    localparam logic [7:0] ADDR_CLK_MODE   = 8'h04; // clock/mode control
    localparam logic [7:0] ADDR_CMP_A      = 8'h08; // compare value a
    localparam logic [7:0] ADDR_CMP_B      = 8'h0C; // compare value b
    localparam logic [7:0] ADDR_CAPTURE    = 8'h10; // capture value
    localparam logic [7:0] ADDR_COUNT      = 8'h14; // count value (ro)
    localparam logic [7:0] ADDR_IRQ_STAT   = 8'h18; // sticky status
    localparam logic [7:0] ADDR_IRQ_MASK   = 8'h1C; // interrupt mask
    localparam logic [7:0] ADDR_PORT_DIR   = 8'h20; // pin direction bits

    // field positions in output mode control
    localparam int ACT_A_HI = 7;
    localparam int ACT_A_LO = 6;
    localparam int ACT_B_HI = 5;
    localparam int ACT_B_LO = 4;
    localparam int WGM_LO_HI = 1;
    localparam int WGM_LO_LO = 0;
    // field positions in clock/mode control
    localparam int WGM_HI_HI = 4;
    localparam int WGM_HI_LO = 3;
    localparam int RUN_BIT   = 0;

    // status bit positions
    localparam int ST_OVF   = 0;
    localparam int ST_CMP_A = 1;
    localparam int ST_CMP_B = 2;
    localparam int ST_W     = 3;

    // reset values
    localparam logic [7:0]  RST_BYTE  = 8'h00;
    localparam logic [15:0] RST_WORD  = 16'h0000;

    // fixed counter limits
    localparam logic [15:0] TOP_MAX   = 16'hFFFF;
    localparam logic [15:0] TOP_8BIT  = 16'h00FF;
    localparam logic [15:0] TOP_9BIT  = 16'h01FF;
    localparam logic [15:0] TOP_10BIT = 16'h03FF;
    localparam logic [15:0] BOTTOM    = 16'h0000;

    // output action codes
    localparam logic [1:0] ACT_OFF    = 2'h0;
    localparam logic [1:0] ACT_TOGGLE = 2'h1;
    localparam logic [1:0] ACT_CLEAR  = 2'h2;
    localparam logic [1:0] ACT_SET    = 2'h3;

    // waveform family
    typedef enum logic [3:0] {
        FAM_NORMAL = 4'h1,
        FAM_FAST   = 4'h2,
        FAM_PHASE  = 4'h4,
        FAM_PFC    = 4'h8
    } tmw_fam_t;

    // where top comes from
    typedef enum logic [4:0] {
        TSRC_MAX  = 5'h01,
        TSRC_8    = 5'h02,
        TSRC_9    = 5'h04,
        TSRC_10   = 5'h08,
        TSRC_CMPA = 5'h10
    } tmw_tsrc_t;

    // counter direction states
    typedef enum logic [1:0] {
        DIR_UP   = 2'h1,
        DIR_DOWN = 2'h2
    } tmw_dir_t;

    // mode codes that decide top_from_icr within each mode pair
    localparam logic [3:0] MODE_PFC_ICR = 4'h8;
    localparam logic [3:0] MODE_PC_OCR  = 4'hB;
    localparam logic [3:0] MODE_FP_ICR  = 4'hE;
    localparam logic [3:0] MODE_CTC_OCR = 4'h4;
    localparam logic [3:0] MODE_CTC_ICR = 4'hC;
endpackage : tmw_pkg
`default_nettype wire

/* rtl/tmw_timer.sv */
// The register addresses and register access over AHB-Lite were decided locally.
`default_nettype none
module tmw_timer (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    output logic             compare_out_a,
    output logic             compare_out_a_oe,
    output logic             compare_out_a_own,
    output logic             compare_out_b,
    output logic             compare_out_b_oe,
    output logic             compare_out_b_own,
    output logic             irq
);
    // software-visible registers and internal state
    logic [7:0]  out_mode_r;        // timer_output_mode_control
    logic [7:0]  clk_mode_r;        // timer_clock_mode_control
    logic [15:0] cmp_a_buf_r;       // compare value a as written
    logic [15:0] cmp_b_buf_r;       // compare value b as written
    logic [15:0] cmp_a_r;           // compare value a in use
    logic [15:0] cmp_b_r;           // compare value b in use
    logic [15:0] capture_value_r;   // capture value (top source)
    logic [15:0] count_value_r;     // counter
    logic [tmw_pkg::ST_W-1:0] stat_r; // sticky events
    logic [tmw_pkg::ST_W-1:0] mask_r; // interrupt mask
    logic [1:0]  port_dir_r;        // direction bits for the two pins
    tmw_pkg::tmw_dir_t dir_r;       // counting direction
    logic        oc_a_r;            // compare output a level
    logic        oc_b_r;            // compare output b level

    // bus address phase capture
    logic        wr_pend_r;         // write data phase pending
    logic [7:0]  wr_addr_r;         // latched write address
    logic        rd_go;             // read accepted this cycle
    logic        wr_go;             // write accepted this cycle

    // decode results
    logic [3:0]  mode;              // full waveform mode
    tmw_pkg::tmw_fam_t  family;     // waveform family
    tmw_pkg::tmw_tsrc_t top_src;    // top source
    logic        top_from_icr;      // top taken from capture value
    logic        toggle_a_ok;       // toggle on a allowed in pwm
    logic [15:0] top;               // current top
    logic        run;               // counter running
    logic        at_top;            // counter equals top
    logic        at_bottom;         // counter equals bottom
    logic        match_a;           // compare match channel a
    logic        match_b;           // compare match channel b
    logic        ovf_evt;           // overflow event
    logic        buf_load;          // load compare buffers now
    logic [15:0] count_nxt;         // next counter value
    tmw_pkg::tmw_dir_t dir_nxt;     // next direction
    logic        oc_a_nxt;          // next output a
    logic        oc_b_nxt;          // next output b
    logic [tmw_pkg::ST_W-1:0] evt;  // events this cycle

    // mode joins upper and lower pairs
    assign mode = {clk_mode_r[tmw_pkg::WGM_HI_HI:tmw_pkg::WGM_HI_LO],
                   out_mode_r[tmw_pkg::WGM_LO_HI:tmw_pkg::WGM_LO_LO]};
    assign run  = clk_mode_r[tmw_pkg::RUN_BIT];

    tmw_mode_decode u_dec (
        .waveform_mode_sel (mode),
        .family            (family),
        .top_src           (top_src),
        .top_from_icr      (top_from_icr),
        .toggle_a_ok       (toggle_a_ok)
    );

    // pick top value
    always_comb begin
        case (top_src)
            tmw_pkg::TSRC_8:    top = tmw_pkg::TOP_8BIT;
            tmw_pkg::TSRC_9:    top = tmw_pkg::TOP_9BIT;
            tmw_pkg::TSRC_10:   top = tmw_pkg::TOP_10BIT;
            tmw_pkg::TSRC_CMPA: top = top_from_icr ? capture_value_r
                                                   : cmp_a_r;
            default:            top = tmw_pkg::TOP_MAX;
        endcase
    end

    assign at_top    = (count_value_r == top);
    assign at_bottom = (count_value_r == tmw_pkg::BOTTOM);
    assign match_a   = run && (count_value_r == cmp_a_r);
    assign match_b   = run && (count_value_r == cmp_b_r);

    // counter step, direction, overflow and buffer load points
    always_comb begin
        count_nxt = count_value_r;
        dir_nxt   = dir_r;
        ovf_evt   = 1'b0;
        buf_load  = 1'b0;
        case (family)
            tmw_pkg::FAM_FAST: begin
                buf_load  = run && at_top;
                ovf_evt   = run && at_top;
                count_nxt = at_top ? tmw_pkg::BOTTOM : count_value_r + 16'h0001;
            end
            tmw_pkg::FAM_PHASE, tmw_pkg::FAM_PFC: begin
                if (family == tmw_pkg::FAM_PHASE) begin
                    buf_load = run && at_top;
                end else begin
                    buf_load = run && at_bottom;
                end
                ovf_evt = run && at_bottom && (dir_r == tmw_pkg::DIR_DOWN);
                if (dir_r == tmw_pkg::DIR_UP) begin
                    if (at_top) begin
                        dir_nxt   = tmw_pkg::DIR_DOWN;
                        count_nxt = count_value_r - 16'h0001;
                    end else begin
                        count_nxt = count_value_r + 16'h0001;
                    end
                end else begin
                    if (at_bottom) begin
                        dir_nxt   = tmw_pkg::DIR_UP;
                        count_nxt = count_value_r + 16'h0001;
                    end else begin
                        count_nxt = count_value_r - 16'h0001;
                    end
                end
            end
            default: begin
                buf_load = 1'b1;                   // immediate
                ovf_evt  = run && (count_value_r == tmw_pkg::TOP_MAX);
                count_nxt = at_top ? tmw_pkg::BOTTOM : count_value_r + 16'h0001;
                dir_nxt  = tmw_pkg::DIR_UP;
            end
        endcase
        if (!run) begin
            count_nxt = count_value_r;
            dir_nxt   = dir_r;
        end
    end

    // output action for one channel
    function automatic logic oc_next(
        input logic       cur,
        input logic [1:0] act,
        input logic       match,
        input logic       cmp_is_top,
        input logic       tog_ok
    );
        logic nv;
        nv = cur;
        case (family)
            tmw_pkg::FAM_FAST: begin
                if (act == tmw_pkg::ACT_TOGGLE) begin
                    if (tog_ok && match) nv = ~cur;
                end else if (act[1]) begin
                    if (run && at_top) nv = ~act[0];
                    else if (match && !cmp_is_top) nv = act[0];
                end
            end
            tmw_pkg::FAM_PHASE, tmw_pkg::FAM_PFC: begin
                if (act == tmw_pkg::ACT_TOGGLE) begin
                    if (tog_ok && match) nv = ~cur;
                end else if (act[1] && match) begin
                    nv = (dir_r == tmw_pkg::DIR_UP) ? act[0] : ~act[0];
                end
            end
            default: begin
                if (match) begin
                    case (act)
                        tmw_pkg::ACT_TOGGLE: nv = ~cur;
                        tmw_pkg::ACT_CLEAR:  nv = 1'b0;
                        tmw_pkg::ACT_SET:    nv = 1'b1;
                        default:             nv = cur;
                    endcase
                end
            end
        endcase
        return nv;
    endfunction : oc_next

    always_comb begin
        oc_a_nxt = oc_next(oc_a_r,
            out_mode_r[tmw_pkg::ACT_A_HI:tmw_pkg::ACT_A_LO],
            match_a, cmp_a_r == top, toggle_a_ok);
        oc_b_nxt = oc_next(oc_b_r,
            out_mode_r[tmw_pkg::ACT_B_HI:tmw_pkg::ACT_B_LO],
            match_b, cmp_b_r == top, 1'b0); // b never toggles in pwm
        if (family == tmw_pkg::FAM_NORMAL) begin
            oc_b_nxt = oc_next(oc_b_r,
                out_mode_r[tmw_pkg::ACT_B_HI:tmw_pkg::ACT_B_LO],
                match_b, 1'b0, 1'b1);
        end
    end

    // bus handshake: zero wait states, always okay
    assign rd_go = hsel && hready && htrans[1] && !hwrite;
    assign wr_go = hsel && hready && htrans[1] && hwrite;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= tmw_pkg::RST_BYTE;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            wr_pend_r <= wr_go;
            if (wr_go) wr_addr_r <= haddr;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // read data registered in the address phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (rd_go) begin
            case (haddr)
                tmw_pkg::ADDR_OUT_MODE: hrdata <= {24'h0, out_mode_r};
                tmw_pkg::ADDR_CLK_MODE: hrdata <= {24'h0, clk_mode_r};
                tmw_pkg::ADDR_CMP_A:    hrdata <= {16'h0, cmp_a_buf_r};
                tmw_pkg::ADDR_CMP_B:    hrdata <= {16'h0, cmp_b_buf_r};
                tmw_pkg::ADDR_CAPTURE:  hrdata <= {16'h0, capture_value_r};
                tmw_pkg::ADDR_COUNT:    hrdata <= {16'h0, count_value_r};
                tmw_pkg::ADDR_IRQ_STAT: hrdata <= {29'h0, stat_r};
                tmw_pkg::ADDR_IRQ_MASK: hrdata <= {29'h0, mask_r};
                tmw_pkg::ADDR_PORT_DIR: hrdata <= {30'h0, port_dir_r};
                default:                hrdata <= 32'h0000_0000;
            endcase
        end
    end

    // control register writes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            out_mode_r      <= tmw_pkg::RST_BYTE;
            clk_mode_r      <= tmw_pkg::RST_BYTE;
            cmp_a_buf_r     <= tmw_pkg::RST_WORD;
            cmp_b_buf_r     <= tmw_pkg::RST_WORD;
            capture_value_r <= tmw_pkg::RST_WORD;
            mask_r          <= '0;
            port_dir_r      <= 2'h0;
        end else if (wr_pend_r) begin
            case (wr_addr_r)
                tmw_pkg::ADDR_OUT_MODE: out_mode_r <= hwdata[7:0];
                tmw_pkg::ADDR_CLK_MODE: clk_mode_r <= hwdata[7:0];
                tmw_pkg::ADDR_CMP_A:    cmp_a_buf_r <= hwdata[15:0];
                tmw_pkg::ADDR_CMP_B:    cmp_b_buf_r <= hwdata[15:0];
                tmw_pkg::ADDR_CAPTURE:  capture_value_r <= hwdata[15:0];
                tmw_pkg::ADDR_IRQ_MASK: mask_r <= hwdata[tmw_pkg::ST_W-1:0];
                tmw_pkg::ADDR_PORT_DIR: port_dir_r <= hwdata[1:0];
                default: ;
            endcase
        end
    end

    // compare values in use follow buffers at the mode's load point
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cmp_a_r <= tmw_pkg::RST_WORD;
            cmp_b_r <= tmw_pkg::RST_WORD;
        end else if (buf_load) begin
            cmp_a_r <= cmp_a_buf_r;
            cmp_b_r <= cmp_b_buf_r;
        end
    end

    // counter, direction and output levels
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count_value_r <= tmw_pkg::RST_WORD;
            dir_r         <= tmw_pkg::DIR_UP;
            oc_a_r        <= 1'b0;
            oc_b_r        <= 1'b0;
        end else begin
            count_value_r <= count_nxt;
            dir_r         <= dir_nxt;
            oc_a_r        <= oc_a_nxt;
            oc_b_r        <= oc_b_nxt;
        end
    end

    // sticky status: set beats write-one-to-clear
    always_comb begin
        evt = '0;
        evt[tmw_pkg::ST_OVF]   = ovf_evt;
        evt[tmw_pkg::ST_CMP_A] = match_a;
        evt[tmw_pkg::ST_CMP_B] = match_b;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stat_r <= '0;
        end else if (wr_pend_r && wr_addr_r == tmw_pkg::ADDR_IRQ_STAT) begin
            stat_r <= (stat_r & ~hwdata[tmw_pkg::ST_W-1:0]) | evt;
        end else begin
            stat_r <= stat_r | evt;
        end
    end

    // pin outputs, all registered
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            compare_out_a     <= 1'b0;
            compare_out_b     <= 1'b0;
            compare_out_a_own <= 1'b0;
            compare_out_b_own <= 1'b0;
            compare_out_a_oe  <= 1'b0;
            compare_out_b_oe  <= 1'b0;
            irq               <= 1'b0;
        end else begin
            compare_out_a     <= oc_a_nxt;
            compare_out_b     <= oc_b_nxt;
            compare_out_a_own <=
                |out_mode_r[tmw_pkg::ACT_A_HI:tmw_pkg::ACT_A_LO];
            compare_out_b_own <=
                |out_mode_r[tmw_pkg::ACT_B_HI:tmw_pkg::ACT_B_LO];
            compare_out_a_oe  <= port_dir_r[0];
            compare_out_b_oe  <= port_dir_r[1];
            irq               <= |((stat_r | evt) & mask_r);
        end
    end
endmodule : tmw_timer
`default_nettype wire

/* tb/testbench.sv */
`default_nettype none
// bus-driven testbench for the waveform timer
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        hclk    = 1'h0;  // 25 MHz bus clock
    logic        hresetn = 1'h0;  // reset, active low
    logic [7:0]  haddr   = 8'h00; // bus address
    logic [1:0]  htrans  = 2'h0;  // transfer kind
    logic        hwrite  = 1'h0;  // write strobe
    logic [31:0] hwdata  = 32'h0; // write data
    logic [31:0] hrdata, rd;      // read data and last read
    logic        hready, hresp, irq, a, a_oe, a_own, b, b_oe, b_own;
    int          err_count = 0;   // mismatches
    int          checks    = 0;   // comparisons made
    logic [31:0] na, nb;          // high-cycle counts, unknowns stick
    int          n;               // wait counter
    always #20 hclk = ~hclk;
    tmw_timer tmw_timer_inst (.hclk(hclk), .hresetn(hresetn), .hsel(1'h1),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hready), .hresp(hresp), .compare_out_a(a),
        .compare_out_a_oe(a_oe), .compare_out_a_own(a_own),
        .compare_out_b(b), .compare_out_b_oe(b_oe),
        .compare_out_b_own(b_own), .irq(irq));
    // compare one value and count it
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    // one single bus transfer; read data lands in rd
    task automatic xfer(input logic [7:0] ad, input logic w,
                        input logic [31:0] d);
        haddr  <= ad;
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge hclk); while (!hready);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (!hready);
        rd = hrdata;
    endtask : xfer
    // reset, then program mode (never 13), actions, compares, top
    task automatic cfg(input logic [3:0] m, input logic [7:0] act,
                       input logic [15:0] c, input logic [15:0] cap);
        hresetn <= 1'h0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'h1;
        @(posedge hclk);
        xfer(tmw_pkg::ADDR_CMP_A, 1'h1, {16'h0, c});
        xfer(tmw_pkg::ADDR_CMP_B, 1'h1, {16'h0, c});
        xfer(tmw_pkg::ADDR_CAPTURE, 1'h1, {16'h0, cap});
        xfer(tmw_pkg::ADDR_PORT_DIR, 1'h1, 32'h3);
        xfer(tmw_pkg::ADDR_OUT_MODE, 1'h1, {24'h0, act[7:4], 2'h0, m[1:0]});
        xfer(tmw_pkg::ADDR_CLK_MODE, 1'h1, {27'h0, m[3:2], 2'h0, 1'h1});
    endtask : cfg
    // settle one window, then count high cycles of both pins
    task automatic run(input logic [3:0] m, input logic [7:0] act,
                       input logic [15:0] c, input logic [15:0] cap,
                       input int per, input int ea, input int eb);
        cfg(m, act, c, cap);
        na = 0;
        nb = 0;
        repeat (per) @(posedge hclk);
        repeat (per) begin
            @(posedge hclk);
            na += {31'h0, a};
            nb += {31'h0, b};
        end
        chk(na, 32'(ea));
        chk(nb, 32'(eb));
    endtask : run
    // report counts and the verdict, then stop
    task automatic print_verdict;
        $display("checks=%0d mismatches=%0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : print_verdict
    // main sequence of tests
    initial begin
        repeat (5) @(posedge hclk);
        hresetn <= 1'h1;
        @(posedge hclk);
        xfer(tmw_pkg::ADDR_OUT_MODE, 1'h0, 32'h0);
        chk(rd, 32'h0);
        for (int i = 0; i < 4; i++) begin
            xfer(tmw_pkg::ADDR_OUT_MODE, 1'h1, {24'h0, i[1:0], ~i[1:0], 4'h0});
            repeat (2) @(posedge hclk);
            chk({31'h0, a_own}, {31'h0, |i[1:0]});
            chk({31'h0, b_own}, {31'h0, |(~i[1:0])});
            xfer(tmw_pkg::ADDR_PORT_DIR, 1'h1, {30'h0, i[1:0]});
            repeat (2) @(posedge hclk);
            chk({30'h0, b_oe, a_oe}, {30'h0, i[1:0]});
        end
        xfer(8'h24, 1'h1, 32'hFFFF_FFFF);
        xfer(8'h24, 1'h0, 32'h0);
        chk(rd, 32'h0);
        $display("test registers done");
        run(4'h4, 8'hB0, 16'h5, 16'h0, 12, 0, 12);
        run(4'h0, 8'hB0, 16'h5, 16'h0, 12, 0, 12);
        run(4'hC, 8'hE0, 16'h5, 16'h5, 12, 12, 0);
        run(4'h4, 8'h50, 16'h5, 16'h0, 12, 6, 6);
        xfer(tmw_pkg::ADDR_COUNT, 1'h0, 32'h0);
        chk(32'(rd <= 32'h5), 32'h1);
        $display("test non-pwm done");
        run(4'h5, 8'hB0, 16'h40, 16'h0, 256, 65, 191);
        run(4'h6, 8'hB0, 16'h40, 16'h0, 512, 65, 447);
        run(4'h7, 8'hB0, 16'h40, 16'h0, 1024, 65, 959);
        run(4'hE, 8'hB0, 16'h40, 16'hFF, 256, 65, 191);
        run(4'h5, 8'hB0, 16'hFF, 16'h0, 256, 256, 0);
        run(4'h5, 8'h50, 16'h40, 16'h0, 256, 0, 0);
        run(4'hF, 8'h50, 16'hFF, 16'h0, 512, 256, 0);
        $display("test fast pwm done");
        run(4'h1, 8'hB0, 16'h40, 16'h0, 510, 128, 382);
        run(4'h2, 8'hB0, 16'h40, 16'h0, 1022, 128, 894);
        run(4'h3, 8'hB0, 16'h40, 16'h0, 2046, 128, 1918);
        run(4'h8, 8'hB0, 16'h40, 16'hFF, 510, 128, 382);
        run(4'hA, 8'hB0, 16'h40, 16'hFF, 510, 128, 382);
        run(4'h1, 8'h50, 16'h40, 16'h0, 510, 0, 0);
        run(4'hB, 8'h50, 16'hFF, 16'h0, 1020, 510, 0);
        run(4'h9, 8'h50, 16'hFF, 16'h0, 1020, 510, 0);
        $display("test dual slope done");
        cfg(4'h5, 8'h00, 16'h0, 16'h0);
        xfer(tmw_pkg::ADDR_IRQ_MASK, 1'h1, 32'h1);
        for (n = 0; n < 300 && irq !== 1'h1; n++) @(posedge hclk);
        chk({31'h0, irq}, 32'h1);
        xfer(tmw_pkg::ADDR_IRQ_STAT, 1'h1, 32'h1);
        xfer(tmw_pkg::ADDR_IRQ_STAT, 1'h0, 32'h0);
        chk({31'h0, rd[0]}, 32'h0);
        chk({31'h0, irq}, 32'h0);
        for (n = 0; n < 300 && irq !== 1'h1; n++) @(posedge hclk);
        chk({31'h0, irq}, 32'h1);
        xfer(tmw_pkg::ADDR_IRQ_MASK, 1'h1, 32'h0);
        repeat (2) @(posedge hclk);
        chk({31'h0, irq}, 32'h0);
        $display("test interrupt done");
        print_verdict();
    end
    // cut a hang short
    initial begin
        repeat (40000) @(posedge hclk);
        err_count++;
        print_verdict();
    end
endmodule : testbench
`default_nettype wire

/* tb/tmw_timer_assertions.sv */
`default_nettype none
// checker for the timer's bus and pin outputs
module tmw_timer_chk (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [7:0]  haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [2:0]  hsize,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        compare_out_a,
    input wire logic        compare_out_a_oe,
    input wire logic        compare_out_a_own,
    input wire logic        compare_out_b,
    input wire logic        compare_out_b_oe,
    input wire logic        compare_out_b_own,
    input wire logic        irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic       wr_r;  // write data phase in progress
    logic [7:0] ad_r;  // address of that data phase
    logic       wo1_r; // output mode written one cycle ago
    logic       wo2_r; // output mode written two cycles ago
    // track the address phase of each accepted write
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_r  <= 1'h0;
            ad_r  <= 8'h00;
            wo1_r <= 1'h0;
            wo2_r <= 1'h0;
        end else begin
            wr_r  <= hsel && hready && htrans[1] && hwrite;
            ad_r  <= haddr;
            wo1_r <= wr_r && (ad_r == tmw_pkg::ADDR_OUT_MODE);
            wo2_r <= wo1_r;
        end
    end
    // write data phase to a given register
    sequence s_wr(logic [7:0] a);
        wr_r && (ad_r == a);
    endsequence
    // a field written reaches its pin flag within two cycles
    property p_fld(logic [7:0] a, logic d, logic o);
        s_wr(a) |-> ##2 (o == $past(d, 2));
    endproperty
    AST_READY: assert property (hreadyout && !hresp)
        else $error("bus slave stalled or answered with error");
    AST_UNMAPPED: assert property (hsel && hready && htrans[1] && !hwrite
        && haddr > tmw_pkg::ADDR_PORT_DIR |=> hrdata == 32'h0)
        else $error("unmapped read returned nonzero data");
    AST_OWN_A: assert property (p_fld(tmw_pkg::ADDR_OUT_MODE,
        |hwdata[7:6], compare_out_a_own)) else $error("pin a ownership");
    AST_OWN_B: assert property (p_fld(tmw_pkg::ADDR_OUT_MODE,
        |hwdata[5:4], compare_out_b_own)) else $error("pin b ownership");
    AST_OE_A: assert property (p_fld(tmw_pkg::ADDR_PORT_DIR,
        hwdata[0], compare_out_a_oe)) else $error("pin a driver enable");
    AST_OE_B: assert property (p_fld(tmw_pkg::ADDR_PORT_DIR,
        hwdata[1], compare_out_b_oe)) else $error("pin b driver enable");
    AST_OWN_HOLD: assert property ($changed(compare_out_a_own)
        |-> wo1_r || wo2_r) else $error("pin a ownership moved alone");
    AST_IRQ_OFF: assert property (s_wr(tmw_pkg::ADDR_IRQ_MASK)
        and (hwdata[2:0] == 3'h0) |-> ##2 !irq[*2])
        else $error("interrupt high with all sources masked");
endmodule : tmw_timer_chk
bind tmw_timer tmw_timer_chk tmw_timer_chk_inst (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .compare_out_a(compare_out_a), .compare_out_a_oe(compare_out_a_oe),
    .compare_out_a_own(compare_out_a_own), .compare_out_b(compare_out_b),
    .compare_out_b_oe(compare_out_b_oe),
    .compare_out_b_own(compare_out_b_own), .irq(irq));
`default_nettype wire
